//--- hw/pdmc_ctrl.sv
// power-down mode controller with apb registers and clock gating
//
// Added by the designer: register access over APB and the address map.
`timescale 1ns/100ps
`default_nettype none
module pdmc_ctrl #(
  parameter int ADDR_W = 8,
  parameter logic [14:0] WAIT_STATES_000 = 15'h2000,
  parameter logic [14:0] WAIT_STATES_001 = 15'h4000
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleep_req,
  input wire logic wake_irq,
  input wire logic timer_clock_source_select,
  input wire logic osc_ready,
  input wire logic watch_tick,
  output logic osc_enable,
  output logic cpu_clk_en,
  output logic cpu_sub_en,
  output logic [pdmc_pkg::NUM_PERIPH-1:0] periph_clk_en,
  output logic [pdmc_pkg::NUM_PERIPH-1:0] periph_sub_en,
  output logic [3:0] power_mode
);
  localparam int NP = pdmc_pkg::NUM_PERIPH;

  logic [7:0] power_mode_control_1;
  logic [7:0] power_mode_control_2;
  logic [NP-1:0] module_clock_run;
  pdmc_pkg::pdmc_state_t state;
  pdmc_pkg::pdmc_state_t next_state;
  logic [pdmc_pkg::WAIT_W-1:0] wait_cnt;
  logic [pdmc_pkg::WAIT_W-1:0] wait_target;
  logic wait_done;
  logic med_tick;
  logic sub_tick;
  logic med_run;
  logic sub_run;
  logic [pdmc_pkg::MED_W-1:0] med_last;
  logic [2:0] sub_last;
  logic [7:0] next_rdata;
  logic addr_ok;
  logic wr_en;
  logic deep_sleep_select;
  logic wake_low_speed_select;
  logic wake_medium_speed_select;
  logic direct_transfer;
  logic [2:0] wake_wait_select;
  pdmc_pkg::pdmc_state_t resume_state;

  assign deep_sleep_select = power_mode_control_1[pdmc_pkg::C1_DEEP_SLEEP];
  assign wake_low_speed_select = power_mode_control_1[pdmc_pkg::C1_LOW_SPEED];
  assign wake_wait_select = power_mode_control_1[pdmc_pkg::C1_WAIT_MSB:pdmc_pkg::C1_WAIT_LSB];
  assign wake_medium_speed_select = power_mode_control_2[pdmc_pkg::C2_MED_SPEED];
  assign direct_transfer = power_mode_control_2[pdmc_pkg::C2_DIRECT];

  // apb slave: no wait states, error on unmapped word
  assign addr_ok = (paddr == pdmc_pkg::ADDR_CTRL1) || (paddr == pdmc_pkg::ADDR_CTRL2) ||
                   (paddr == pdmc_pkg::ADDR_MODRUN) || (paddr == pdmc_pkg::ADDR_STATUS);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign wr_en = psel && penable && pwrite && addr_ok;

  // reserved bits keep their reset value through the masks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_mode_control_1 <= pdmc_pkg::CTRL1_RESET;
      power_mode_control_2 <= pdmc_pkg::CTRL2_RESET;
      module_clock_run <= pdmc_pkg::MODRUN_RESET;
    end else if (wr_en) begin
      if (paddr == pdmc_pkg::ADDR_CTRL1) begin
        power_mode_control_1 <= (pwdata[7:0] & pdmc_pkg::CTRL1_WMASK) |
                                (pdmc_pkg::CTRL1_RESET & ~pdmc_pkg::CTRL1_WMASK);
      end
      if (paddr == pdmc_pkg::ADDR_CTRL2) begin
        power_mode_control_2 <= (pwdata[7:0] & pdmc_pkg::CTRL2_WMASK) |
                                (pdmc_pkg::CTRL2_RESET & ~pdmc_pkg::CTRL2_WMASK);
      end
      if (paddr == pdmc_pkg::ADDR_MODRUN) begin
        module_clock_run <= pwdata[NP-1:0];
      end
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    if (paddr == pdmc_pkg::ADDR_CTRL1) begin
      next_rdata = power_mode_control_1;
    end else if (paddr == pdmc_pkg::ADDR_CTRL2) begin
      next_rdata = power_mode_control_2;
    end else if (paddr == pdmc_pkg::ADDR_MODRUN) begin
      next_rdata = module_clock_run;
    end else if (paddr == pdmc_pkg::ADDR_STATUS) begin
      next_rdata[3:0] = state;
      next_rdata[pdmc_pkg::ST_OSC] = osc_enable;
      next_rdata[pdmc_pkg::ST_WAIT] = (state == pdmc_pkg::PDMC_OSC_WAIT);
    end
  end

  // read data captured in the setup cycle, stands through the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {24'h00_0000, next_rdata};
    end
  end

  always_comb begin
    unique case (wake_wait_select)
      3'h0: wait_target = WAIT_STATES_000;
      3'h1: wait_target = WAIT_STATES_001;
      3'h2: wait_target = pdmc_pkg::WAIT_1024;
      3'h3: wait_target = pdmc_pkg::WAIT_2048;
      3'h4: wait_target = pdmc_pkg::WAIT_4096;
      3'h5: wait_target = pdmc_pkg::WAIT_EXT;
      3'h6: wait_target = pdmc_pkg::WAIT_8;
      3'h7: wait_target = pdmc_pkg::WAIT_16;
    endcase
  end

  // counting only starts once the oscillator reports it has settled
  assign wait_done = osc_ready && (wait_cnt >= wait_target - 1'b1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cnt <= '0;
    end else if (state != pdmc_pkg::PDMC_OSC_WAIT) begin
      wait_cnt <= '0;
    end else if (osc_ready && !wait_done) begin
      wait_cnt <= wait_cnt + 1'b1;
    end
  end

  assign resume_state = wake_medium_speed_select ? pdmc_pkg::PDMC_ACT_MED : pdmc_pkg::PDMC_ACT_HI;

  always_comb begin
    next_state = state;
    unique case (state)
      pdmc_pkg::PDMC_ACT_HI, pdmc_pkg::PDMC_ACT_MED: begin
        if (sleep_req && !direct_transfer) begin
          if (!deep_sleep_select && !wake_low_speed_select) begin
            next_state = wake_medium_speed_select ? pdmc_pkg::PDMC_SLP_MED : pdmc_pkg::PDMC_SLP_HI;
          end else if (!deep_sleep_select && timer_clock_source_select) begin
            next_state = pdmc_pkg::PDMC_SUBSLP;
          end else if (deep_sleep_select && timer_clock_source_select) begin
            next_state = pdmc_pkg::PDMC_WATCH;
          end else if (deep_sleep_select && !wake_low_speed_select) begin
            next_state = pdmc_pkg::PDMC_STBY;
          end
        end else if (sleep_req) begin
          if (!deep_sleep_select && !wake_low_speed_select) begin
            next_state = resume_state;
          end else if (deep_sleep_select && wake_low_speed_select && timer_clock_source_select) begin
            next_state = pdmc_pkg::PDMC_SUBACT;
          end
        end
      end
      pdmc_pkg::PDMC_SUBACT: begin
        if (sleep_req && direct_transfer && !wake_low_speed_select) begin
          next_state = pdmc_pkg::PDMC_OSC_WAIT;
        end else if (sleep_req && !direct_transfer && timer_clock_source_select) begin
          next_state = deep_sleep_select ? pdmc_pkg::PDMC_WATCH : pdmc_pkg::PDMC_SUBSLP;
        end
      end
      pdmc_pkg::PDMC_SLP_HI, pdmc_pkg::PDMC_SLP_MED: begin
        if (wake_irq) begin
          next_state = resume_state;
        end
      end
      pdmc_pkg::PDMC_SUBSLP: begin
        if (wake_irq) begin
          next_state = pdmc_pkg::PDMC_SUBACT;
        end
      end
      pdmc_pkg::PDMC_WATCH: begin
        if (wake_irq) begin
          next_state = wake_low_speed_select ? pdmc_pkg::PDMC_SUBACT : pdmc_pkg::PDMC_OSC_WAIT;
        end
      end
      pdmc_pkg::PDMC_STBY: begin
        if (wake_irq) begin
          next_state = pdmc_pkg::PDMC_OSC_WAIT;
        end
      end
      pdmc_pkg::PDMC_OSC_WAIT: begin
        if (wait_done) begin
          next_state = resume_state;
        end
      end
      default: next_state = pdmc_pkg::PDMC_ACT_HI;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= pdmc_pkg::PDMC_ACT_HI;
    end else begin
      state <= next_state;
    end
  end

  // oscillator follows the next state so it restarts on the accepting edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_enable <= 1'b1;
    end else begin
      osc_enable <= !(next_state inside {pdmc_pkg::PDMC_STBY, pdmc_pkg::PDMC_WATCH,
                                          pdmc_pkg::PDMC_SUBACT, pdmc_pkg::PDMC_SUBSLP});
    end
  end

  assign med_run = (state == pdmc_pkg::PDMC_ACT_MED) || (state == pdmc_pkg::PDMC_SLP_MED);
  assign med_last = pdmc_pkg::MED_W'((pdmc_pkg::MED_BASE << power_mode_control_1[pdmc_pkg::C1_MED_MSB:pdmc_pkg::C1_MED_LSB])
                    - 8'h01);
  assign sub_run = (state == pdmc_pkg::PDMC_SUBACT) || (state == pdmc_pkg::PDMC_SUBSLP);
  // sub select 1x means divide by two
  assign sub_last = power_mode_control_2[pdmc_pkg::C2_SUB_MSB] ? 3'(pdmc_pkg::SUB_BASE >> 2'h2) - 3'h1 :
                    3'((pdmc_pkg::SUB_BASE >> power_mode_control_2[pdmc_pkg::C2_SUB_LSB]) - 4'h1);

  pdmc_divider #(.CNT_W(pdmc_pkg::MED_W)) u_med_div (
    .pclk(pclk),
    .presetn(presetn),
    .run(med_run),
    .src_tick(1'b1),
    .last(med_last),
    .tick(med_tick)
  );

  pdmc_divider #(.CNT_W(3)) u_sub_div (
    .pclk(pclk),
    .presetn(presetn),
    .run(sub_run),
    .src_tick(watch_tick),
    .last(sub_last),
    .tick(sub_tick)
  );

  // clock enables stay high in the high-speed modes and pulse once per divided period in the medium-speed modes, the cpu gate only while active
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_clk_en <= 1'b0;
      cpu_sub_en <= 1'b0;
    end else begin
      cpu_clk_en <= (state == pdmc_pkg::PDMC_ACT_HI) || ((state == pdmc_pkg::PDMC_ACT_MED) && med_tick);
      cpu_sub_en <= (state == pdmc_pkg::PDMC_SUBACT) && sub_tick;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_clk_en <= '0;
    end else if ((state == pdmc_pkg::PDMC_ACT_HI) || (state == pdmc_pkg::PDMC_SLP_HI)) begin
      periph_clk_en <= module_clock_run;
    end else if (med_run && med_tick) begin
      periph_clk_en <= module_clock_run;
    end else begin
      periph_clk_en <= '0;
    end
  end

  // watch mode runs the timekeeping peripherals straight off the watch clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_sub_en <= '0;
    end else if ((state == pdmc_pkg::PDMC_SUBACT) && sub_tick) begin
      periph_sub_en <= module_clock_run;
    end else if ((state == pdmc_pkg::PDMC_SUBSLP) && sub_tick) begin
      periph_sub_en <= module_clock_run & pdmc_pkg::SUBSLEEP_MASK;
    end else if ((state == pdmc_pkg::PDMC_WATCH) && watch_tick) begin
      periph_sub_en <= module_clock_run & pdmc_pkg::WATCH_MASK;
    end else begin
      periph_sub_en <= '0;
    end
  end

  assign power_mode = state;

  a_osc_stops: assert property (@(posedge pclk) disable iff (!presetn)
    (state inside {pdmc_pkg::PDMC_STBY, pdmc_pkg::PDMC_WATCH, pdmc_pkg::PDMC_SUBACT}) |-> !osc_enable)
    else $error("oscillator running in a stop mode");

  a_osc_restart: assert property (@(posedge pclk) disable iff (!presetn)
    (state == pdmc_pkg::PDMC_STBY && wake_irq) |=> osc_enable && state == pdmc_pkg::PDMC_OSC_WAIT)
    else $error("oscillator not restarted on wake");

  a_wait_holds: assert property (@(posedge pclk) disable iff (!presetn)
    (state == pdmc_pkg::PDMC_OSC_WAIT && !wait_done) |=> state == pdmc_pkg::PDMC_OSC_WAIT && !cpu_clk_en)
    else $error("clocks released before wait expired");

  a_wait_eight: assert property (@(posedge pclk) disable iff (!presetn)
    (state == pdmc_pkg::PDMC_OSC_WAIT && osc_ready && wake_wait_select == 3'h6 && wait_cnt == '0)
    |-> (state == pdmc_pkg::PDMC_OSC_WAIT && osc_ready) [*8] ##1 state != pdmc_pkg::PDMC_OSC_WAIT)
    else $error("eight state wait not kept");

  a_settle_first: assert property (@(posedge pclk) disable iff (!presetn)
    (state == pdmc_pkg::PDMC_OSC_WAIT && !osc_ready) |=> $stable(wait_cnt) && state == pdmc_pkg::PDMC_OSC_WAIT)
    else $error("wait counted before oscillator settled");

  a_sleep_entry: assert property (@(posedge pclk) disable iff (!presetn)
    (state == pdmc_pkg::PDMC_ACT_HI && sleep_req && !direct_transfer && !deep_sleep_select
     && !wake_low_speed_select && !wake_medium_speed_select) |=> state == pdmc_pkg::PDMC_SLP_HI)
    else $error("sleep request did not enter high-speed sleep");

  a_sleep_cpu_off: assert property (@(posedge pclk) disable iff (!presetn)
    (state == pdmc_pkg::PDMC_SLP_HI) |=> !cpu_clk_en && periph_clk_en == $past(module_clock_run))
    else $error("sleep gating wrong");

  a_standby_dark: assert property (@(posedge pclk) disable iff (!presetn)
    (state == pdmc_pkg::PDMC_STBY) |=> periph_clk_en == '0 && periph_sub_en == '0 && !cpu_clk_en && !cpu_sub_en)
    else $error("clock running in standby");

  a_watch_set: assert property (@(posedge pclk) disable iff (!presetn)
    (state == pdmc_pkg::PDMC_WATCH) |=> (periph_sub_en & ~pdmc_pkg::WATCH_MASK) == '0 && !cpu_sub_en)
    else $error("watch mode clocks a stopped peripheral");

  a_module_halt: assert property (@(posedge pclk) disable iff (!presetn)
    ((periph_clk_en | periph_sub_en) & ~$past(module_clock_run)) == '0)
    else $error("halted peripheral received a clock");

  a_watch_wake: assert property (@(posedge pclk) disable iff (!presetn)
    (state == pdmc_pkg::PDMC_WATCH && wake_irq && wake_low_speed_select) |=> state == pdmc_pkg::PDMC_SUBACT)
    else $error("watch wake ignored low-speed select");
endmodule
`default_nettype wire

//--- hw/pdmc_pkg.sv
// constants and types for the power-down mode controller
package pdmc_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL1 = 8'h00;
  localparam logic [7:0] ADDR_CTRL2 = 8'h04;
  localparam logic [7:0] ADDR_MODRUN = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  // power_mode_control_1 fields
  localparam int C1_DEEP_SLEEP = 7;
  localparam int C1_WAIT_MSB = 6;
  localparam int C1_WAIT_LSB = 4;
  localparam int C1_LOW_SPEED = 3;
  localparam int C1_MED_MSB = 1;
  localparam int C1_MED_LSB = 0;
  localparam logic [7:0] CTRL1_RESET = 8'h07;
  localparam logic [7:0] CTRL1_WMASK = 8'hfb;
  // power_mode_control_2 fields
  localparam int C2_DIRECT = 3;
  localparam int C2_MED_SPEED = 2;
  localparam int C2_SUB_MSB = 1;
  localparam int C2_SUB_LSB = 0;
  localparam logic [7:0] CTRL2_RESET = 8'hf0;
  localparam logic [7:0] CTRL2_WMASK = 8'h1f;
  // module_clock_run and power_status
  localparam logic [7:0] MODRUN_RESET = 8'hff;
  localparam int ST_OSC = 4;
  localparam int ST_WAIT = 5;
  // peripheral slots of the clock enable vectors
  localparam int NUM_PERIPH = 8;
  localparam int PER_TIMER_A = 0;
  localparam int PER_TIMER_F = 1;
  localparam int PER_SERIAL = 2;
  localparam int PER_ADC = 3;
  localparam int PER_AEC = 4;
  localparam int PER_DISPLAY = 5;
  localparam logic [7:0] SUBSLEEP_MASK = 8'h37;
  localparam logic [7:0] WATCH_MASK = 8'h33;
  // wake wait lengths in system clock states
  localparam int WAIT_W = 15;
  localparam logic [14:0] WAIT_1024 = 15'h0400;
  localparam logic [14:0] WAIT_2048 = 15'h0800;
  localparam logic [14:0] WAIT_4096 = 15'h1000;
  localparam logic [14:0] WAIT_EXT = 15'h0002;
  localparam logic [14:0] WAIT_8 = 15'h0008;
  localparam logic [14:0] WAIT_16 = 15'h0010;
  // dividers: medium speed 16 << sel, subclock 8 >> sel with sel 1x giving 2
  localparam int MED_W = 7;
  localparam logic [7:0] MED_BASE = 8'h10;
  localparam logic [3:0] SUB_BASE = 4'h8;
  typedef enum logic [3:0] {
    PDMC_ACT_HI = 4'h0,
    PDMC_ACT_MED = 4'h1,
    PDMC_SUBACT = 4'h2,
    PDMC_SLP_HI = 4'h3,
    PDMC_SLP_MED = 4'h4,
    PDMC_SUBSLP = 4'h5,
    PDMC_WATCH = 4'h6,
    PDMC_STBY = 4'h7,
    PDMC_OSC_WAIT = 4'h8
  } pdmc_state_t;
endpackage

//--- hw/pdmc_divider.sv
// tick divider: one output pulse per (last + 1) source ticks
`timescale 1ns/100ps
`default_nettype none
module pdmc_divider #(
  parameter int CNT_W = 7
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic src_tick,
  input wire logic [CNT_W-1:0] last,
  output logic tick
);
  logic [CNT_W-1:0] cnt;

  // stopped divider restarts from zero, like a prescaler cleared in stop modes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
      tick <= 1'b0;
    end else if (!run) begin
      cnt <= '0;
      tick <= 1'b0;
    end else if (src_tick) begin
      tick <= (cnt >= last);
      cnt <= (cnt >= last) ? '0 : cnt + 1'b1;
    end else begin
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- tb/pdmc_partner.sv
// model of the system oscillator and the watch clock source around the controller
`timescale 1ns/100ps
`default_nettype none
module pdmc_partner #(
  parameter int SETTLE = 20,
  parameter int WDIV = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic osc_enable,
  output logic osc_ready,
  output logic watch_tick
);
  int settle_cnt;
  int wcnt;
  // ready only after a real settling delay, dropped at once when stopped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_cnt <= 0;
      osc_ready <= 1'b0;
    end else if (!osc_enable) begin
      settle_cnt <= 0;
      osc_ready <= 1'b0;
    end else if (settle_cnt < SETTLE) begin
      settle_cnt <= settle_cnt + 1;
    end else begin
      osc_ready <= 1'b1;
    end
  end
  // watch clock keeps running in every mode, one pulse per period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wcnt <= 0;
      watch_tick <= 1'b0;
    end else begin
      wcnt <= (wcnt == WDIV - 1) ? 0 : wcnt + 1;
      watch_tick <= (wcnt == WDIV - 1);
    end
  end
endmodule
`default_nettype wire

//--- tb/power_down_mode_control_tb.sv
// self-checking bench for the power-down mode controller
`timescale 1ns/100ps
`default_nettype none
module power_down_mode_control_tb;
  localparam int WDIV = 4;
  localparam int EXPW[8] = '{32, 64, 1024, 2048, 4096, 2, 8, 16};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic sleep_req, wake_irq, tmr_src, osc_ready, watch_tick, err;
  logic osc_enable, cpu_clk_en, cpu_sub_en;
  logic [7:0] periph_clk_en, periph_sub_en, acc;
  logic [3:0] power_mode;
  int num_errors = 0;
  int cmp_count = 0;
  int n;
  int g;

  pdmc_ctrl #(.ADDR_W(8), .WAIT_STATES_000(15'h0020), .WAIT_STATES_001(15'h0040)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep_req(sleep_req), .wake_irq(wake_irq), .timer_clock_source_select(tmr_src),
    .osc_ready(osc_ready), .watch_tick(watch_tick), .osc_enable(osc_enable),
    .cpu_clk_en(cpu_clk_en), .cpu_sub_en(cpu_sub_en), .periph_clk_en(periph_clk_en),
    .periph_sub_en(periph_sub_en), .power_mode(power_mode));
  pdmc_partner #(.SETTLE(20), .WDIV(WDIV)) osc_model (
    .pclk(pclk), .presetn(presetn), .osc_enable(osc_enable),
    .osc_ready(osc_ready), .watch_tick(watch_tick));

  always #5 pclk = ~pclk;

  task finish_test;
    $display("compares %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task step;
    @(posedge pclk);
    #1;
  endtask

  // request held until pready is seen high at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      num_errors++;
      finish_test;
    end
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask

  task rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rdat, e);
  endtask

  // returns just after the edge that sampled the request
  task pulse(input bit wake);
    @(posedge pclk);
    if (wake) wake_irq <= 1'b1;
    else sleep_req <= 1'b1;
    @(posedge pclk);
    wake_irq <= 1'b0;
    sleep_req <= 1'b0;
    #1;
  endtask

  // counts edges spent in the wake wait with the oscillator settled
  task wait_osc;
    int i;
    n = 0;
    for (i = 0; i < 20000 && power_mode === 4'h8; i++) begin
      @(negedge pclk);
      if (power_mode === 4'h8 && osc_ready === 1'b1) n++;
      step;
    end
    if (i == 20000) begin
      num_errors++;
      finish_test;
    end
  endtask

  // first gap after a divider change may be short, so callers measure twice
  task gap(input bit sub);
    int i;
    for (i = 0; i < 600; i++) begin
      step;
      if ((sub ? cpu_sub_en : cpu_clk_en) === 1'b1) break;
    end
    for (g = 1; g < 600; g++) begin
      step;
      if ((sub ? cpu_sub_en : cpu_clk_en) === 1'b1) break;
    end
    if (i == 600 || g == 600) begin
      num_errors++;
      finish_test;
    end
  endtask

  task sub_acc(input int cycles);
    acc = 8'h00;
    repeat (cycles) begin
      step;
      acc = acc | periph_sub_en;
    end
  endtask

  task test_regs;
    rchk(pdmc_pkg::ADDR_CTRL1, 32'h07);
    rchk(pdmc_pkg::ADDR_CTRL2, 32'hf0);
    rchk(pdmc_pkg::ADDR_MODRUN, 32'hff);
    rchk(pdmc_pkg::ADDR_STATUS, 32'h10);
    apb(1'b1, 8'h10, 32'hff);
    check(32'(err), 32'h1);
    wr(pdmc_pkg::ADDR_CTRL1, 8'hff);
    rchk(pdmc_pkg::ADDR_CTRL1, 32'hff);
    wr(pdmc_pkg::ADDR_CTRL1, 8'h00);
    rchk(pdmc_pkg::ADDR_CTRL1, 32'h04);
    wr(pdmc_pkg::ADDR_CTRL2, 8'h00);
    rchk(pdmc_pkg::ADDR_CTRL2, 32'he0);
    $display("register test finished");
  endtask

  task test_sleep;
    for (int med = 0; med < 2; med++) begin
      wr(pdmc_pkg::ADDR_CTRL2, 8'(med << 2));
      pulse(1'b0);
      check(32'(power_mode), 32'(3 + med));
      step;
      check(32'(cpu_clk_en), 32'h0);
      if (med == 0) check(32'(periph_clk_en), 32'hff);
      pulse(1'b1);
      check(32'(power_mode), 32'(med));
    end
    for (int sel = 0; sel < 4; sel++) begin
      wr(pdmc_pkg::ADDR_CTRL1, 8'(sel));
      gap(1'b0);
      gap(1'b0);
      check(32'(g), 32'(16 << sel));
    end
    wr(pdmc_pkg::ADDR_CTRL2, 8'h00);
    pulse(1'b0);
    pulse(1'b1);
    check(32'(power_mode), 32'h0);
    $display("sleep test finished");
  endtask

  // the long codes stand for the cautious software setting
  task test_standby;
    for (int code = 0; code < 8; code++) begin
      wr(pdmc_pkg::ADDR_CTRL1, {1'b1, 3'(code), 4'h0});
      pulse(1'b0);
      check(32'(power_mode), 32'h7);
      step;
      check({osc_enable, cpu_clk_en, cpu_sub_en, periph_clk_en, periph_sub_en}, 32'h0);
      pulse(1'b1);
      check({osc_enable, power_mode}, 32'h18);
      wait_osc;
      check(32'(n), 32'(EXPW[code]));
      check(32'(power_mode), 32'h0);
      step;
      check(32'(cpu_clk_en), 32'h1);
    end
    $display("standby test finished");
  endtask

  task test_sub;
    @(posedge pclk);
    tmr_src <= 1'b1;
    wr(pdmc_pkg::ADDR_CTRL1, 8'h88);
    pulse(1'b0);
    check(32'(power_mode), 32'h6);
    sub_acc(80);
    check({osc_enable, cpu_clk_en, periph_clk_en, acc}, 32'(pdmc_pkg::WATCH_MASK));
    pulse(1'b1);
    check({osc_enable, power_mode}, 32'h02);
    for (int sel = 0; sel < 3; sel++) begin
      wr(pdmc_pkg::ADDR_CTRL2, 8'(sel));
      wr(pdmc_pkg::ADDR_CTRL1, 8'h08);
      pulse(1'b0);
      check(32'(power_mode), 32'h5);
      sub_acc(80);
      check({cpu_sub_en, periph_clk_en, acc}, 32'(pdmc_pkg::SUBSLEEP_MASK));
      pulse(1'b1);
      check(32'(power_mode), 32'h2);
      gap(1'b1);
      gap(1'b1);
      check(32'(g), 32'((8 >> sel) * WDIV));
    end
    wr(pdmc_pkg::ADDR_CTRL1, 8'h80);
    pulse(1'b0);
    check(32'(power_mode), 32'h6);
    pulse(1'b1);
    check({osc_enable, power_mode}, 32'h18);
    wait_osc;
    check(32'(n), 32'h20);
    check(32'(power_mode), 32'h0);
    @(posedge pclk);
    tmr_src <= 1'b0;
    $display("subclock test finished");
  endtask

  // speed changes and subactive entry without a sleep step, the cpu held only in the oscillator wait out of subactive
  task test_direct;
    @(posedge pclk);
    tmr_src <= 1'b1;
    wr(pdmc_pkg::ADDR_CTRL2, 8'h0c);
    wr(pdmc_pkg::ADDR_CTRL1, 8'h00);
    pulse(1'b0);
    check(32'(power_mode), 32'h1);
    wr(pdmc_pkg::ADDR_CTRL1, 8'h88);
    pulse(1'b0);
    check({osc_enable, power_mode}, 32'h02);
    wr(pdmc_pkg::ADDR_CTRL1, 8'h80);
    pulse(1'b0);
    check({osc_enable, power_mode}, 32'h18);
    wait_osc;
    check(32'(n), 32'h20);
    check(32'(power_mode), 32'h1);
    wr(pdmc_pkg::ADDR_CTRL2, 8'h08);
    wr(pdmc_pkg::ADDR_CTRL1, 8'h00);
    pulse(1'b0);
    check(32'(power_mode), 32'h0);
    @(posedge pclk);
    tmr_src <= 1'b0;
    $display("direct transfer test finished");
  endtask

  task test_modrun;
    wr(pdmc_pkg::ADDR_MODRUN, 8'h5a);
    step;
    step;
    check(32'(periph_clk_en), 32'h5a);
    wr(pdmc_pkg::ADDR_MODRUN, 8'hff);
    step;
    step;
    check(32'(periph_clk_en), 32'hff);
    $display("module halt test finished");
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    sleep_req = 1'b0;
    wake_irq = 1'b0;
    tmr_src = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    test_regs;
    test_sleep;
    test_standby;
    test_sub;
    test_modrun;
    test_direct;
    finish_test;
  end

  // bound well over the length of the whole run
  initial begin
    #900000;
    num_errors++;
    finish_test;
  end
endmodule
`default_nettype wire
